//--- core/gpio_defines.vh
// Constants for the eight-port general-purpose I/O block.
`ifndef GPIO_DEFINES_VH
`define GPIO_DEFINES_VH
`define PORT_W 8
`define NUM_PORTS 8
`define INPUT_PORT_IDX 2
`define RT_PORT_IDX 0
`define RT_NIBBLE_W 4
`define NO_PULLUP_PORT_IDX 7
`define PULLUP_GROUP_LSB 2
`define LATCH_RESET 8'h00
`define DIR_RESET 8'hff
`define RT_TRIG_TIMER 2'h1
`define RT_TRIG_EXT 2'h2
`endif

//--- core/multi_port_gpio.v
// Eight 8-bit general-purpose ports with pull-ups and real-time nibbles.
// Notes on behaviour
// - Every bit of bidirectional ports has its own direction select.
// - Input-only port never drives; one pull-up setting covers its top six pins.
// - Port pull-up setting enables pull-ups only on pins in input mode.
// - Port zero offers two independent 4-bit real-time output nibbles.
// - Ports zero to six have pull-up options; port seven has none.
// - Real-time nibble buffer copies into port zero latch on a trigger in a cycle without a software write to it.
`timescale 1ns/100ps
`include "gpio_defines.vh"
module multi_port_gpio #(
  parameter W = `PORT_W,
  parameter N = `NUM_PORTS
) (
  input wire core_clk_i,
  input wire reset_i,
  input wire [N*W-1:0] latch_wdata_i,
  input wire [N-1:0] latch_we_i,
  input wire [N*W-1:0] dir_in_i,
  input wire [N-1:0] pullup_sel_i,
  input wire [W-1:0] rt_buffer_i,
  input wire [1:0] rt_low_trig_sel_i,
  input wire [1:0] rt_high_trig_sel_i,
  input wire timer1_match_i,
  input wire ext_trig_i,
  input wire [N*W-1:0] pin_i,
  output wire [N*W-1:0] pin_o,
  output wire [N*W-1:0] pin_oe_n_o,
  output wire [N*W-1:0] pullup_en_o,
  output wire [N*W-1:0] read_data_o
);
  // Fixed port roles; widths and the port count stay parameters.
  localparam IN_PORT = `INPUT_PORT_IDX;
  localparam NO_PU_PORT = `NO_PULLUP_PORT_IDX;
  localparam RT_PORT = `RT_PORT_IDX;
  localparam NIB = `RT_NIBBLE_W;
  localparam PU_LSB = `PULLUP_GROUP_LSB;

  reg ext_s1;
  reg ext_s2;
  reg ext_s3;
  reg ext_level;
  reg ext_prev;
  wire ext_rise;
  reg fire_low;
  reg fire_high;

  // The trigger pin is asynchronous and passes three flip-flops.
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      ext_s1 <= 1'h0;
      ext_s2 <= 1'h0;
      ext_s3 <= 1'h0;
    end else begin
      ext_s1 <= ext_trig_i;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // A new level counts only once the last two stages agree, so a pulse of
  // a single clock never reaches the edge detector.
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      ext_level <= 1'h0;
      ext_prev <= 1'h0;
    end else begin
      if (ext_s2 == ext_s3) begin
        ext_level <= ext_s3;
      end
      ext_prev <= ext_level;
    end
  end

  // Both detector stages reset low, the idle level of the trigger pin. A pin
  // that is already high when reset ends therefore counts as one edge.
  assign ext_rise = ext_level & ~ext_prev;

  // Trigger select for the low nibble; codes 0 and 3 leave it as plain I/O.
  always @* begin
    case (rt_low_trig_sel_i)
      `RT_TRIG_TIMER: begin
        fire_low = timer1_match_i;
      end
      `RT_TRIG_EXT: begin
        fire_low = ext_rise;
      end
      default: begin
        fire_low = 1'h0;
      end
    endcase
  end

  // The high nibble has its own select, so both halves run independently.
  always @* begin
    case (rt_high_trig_sel_i)
      `RT_TRIG_TIMER: begin
        fire_high = timer1_match_i;
      end
      `RT_TRIG_EXT: begin
        fire_high = ext_rise;
      end
      default: begin
        fire_high = 1'h0;
      end
    endcase
  end

  // One slice per port: latch, direction, pin filter and read-back.
  genvar p;
  generate
    for (p = 0; p < N; p = p + 1) begin : g_port
      // Per-port state.
      reg [W-1:0] latch;
      reg [W-1:0] next_latch;
      reg [W-1:0] dir_in;
      reg [W-1:0] sync1;
      reg [W-1:0] sync2;
      reg [W-1:0] sync3;
      reg [W-1:0] level;
      reg [W-1:0] drive;
      reg [W-1:0] rdata;

      // A set direction bit makes the pin an input.
      always @(posedge core_clk_i) begin
        if (reset_i) begin
          dir_in <= `DIR_RESET;
        end else if (p == IN_PORT) begin
          dir_in <= {W{1'h1}};
        end else begin
          dir_in <= dir_in_i[p*W +: W];
        end
      end

      if (p == RT_PORT) begin : g_rt
        // A software write wins over a real-time copy in the same cycle and
        // the copy is lost; software should leave the latch alone while armed.
        always @* begin
          next_latch = latch;
          if (latch_we_i[p]) begin
            next_latch = latch_wdata_i[p*W +: W];
          end else begin
            if (fire_low) begin
              next_latch[NIB-1:0] = rt_buffer_i[NIB-1:0];
            end
            if (fire_high) begin
              next_latch[W-1:NIB] = rt_buffer_i[W-1:NIB];
            end
          end
        end
      end else begin : g_plain
        always @* begin
          next_latch = latch;
          if (latch_we_i[p]) begin
            next_latch = latch_wdata_i[p*W +: W];
          end
        end
      end

      always @(posedge core_clk_i) begin
        if (reset_i) begin
          latch <= `LATCH_RESET;
        end else begin
          latch <= next_latch;
        end
      end

      // Pin levels pass three flip-flops before any use.
      always @(posedge core_clk_i) begin
        if (reset_i) begin
          sync1 <= {W{1'h0}};
          sync2 <= {W{1'h0}};
          sync3 <= {W{1'h0}};
        end else begin
          sync1 <= pin_i[p*W +: W];
          sync2 <= sync1;
          sync3 <= sync2;
        end
      end

      // Each bit takes a new level once the last two stages agree, and holds
      // its old one while they differ.
      always @(posedge core_clk_i) begin
        if (reset_i) begin
          level <= {W{1'h0}};
        end else begin
          level <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & level);
        end
      end

      // The pin follows the latch one clock late, the price of a registered
      // output. Input bits read the filtered pin, output bits their latch.
      always @(posedge core_clk_i) begin
        if (reset_i) begin
          drive <= {W{1'h0}};
          rdata <= {W{1'h0}};
        end else begin
          drive <= latch;
          rdata <= (dir_in & level) | (~dir_in & latch);
        end
      end

      assign pin_o[p*W +: W] = drive;
      assign read_data_o[p*W +: W] = rdata;

      if (p == IN_PORT) begin : g_in_only
        // Writes to this port are kept in its latch but never reach a pin.
        assign pin_oe_n_o[p*W +: W] = {W{1'h1}};
        assign pullup_en_o[p*W +: W] =
          {{(W-PU_LSB){pullup_sel_i[p]}}, {PU_LSB{1'h0}}};
      end else if (p == NO_PU_PORT) begin : g_no_pu
        assign pin_oe_n_o[p*W +: W] = dir_in;
        assign pullup_en_o[p*W +: W] = {W{1'h0}};
      end else begin : g_bidir
        assign pin_oe_n_o[p*W +: W] = dir_in;
        assign pullup_en_o[p*W +: W] = dir_in & {W{pullup_sel_i[p]}};
      end
    end
  endgenerate
endmodule

//--- tb/ext_pins.sv
// Board-side model of the pins: drivers, pull-ups and floating lines.
`timescale 1ns/100ps
module ext_pins (
  input wire clk_i,
  input wire [63:0] pin_drv_i,
  input wire [63:0] oe_n_i,
  input wire [63:0] pu_i,
  input wire [63:0] drv_i,
  input wire [63:0] drv_en_i,
  output wire [63:0] pin_i
);
  // A floating line without pull-up toggles so it never reads as a level.
  logic [63:0] pat = 64'h5555555555555555;
  always @(posedge clk_i) pat <= ~pat;
  assign pin_i = (~oe_n_i & pin_drv_i) | (oe_n_i & drv_en_i & drv_i) |
    (oe_n_i & ~drv_en_i & (pu_i | pat));
endmodule

//--- tb/gpio_checker.sv
// Port assertions for the eight-port I/O block.
`timescale 1ns/100ps
module gpio_checker (
  input wire core_clk_i,
  input wire reset_i,
  input wire timer1_match_i,
  input wire [63:0] latch_wdata_i,
  input wire [63:0] dir_in_i,
  input wire [63:0] pin_o,
  input wire [63:0] pin_oe_n_o,
  input wire [63:0] pullup_en_o,
  input wire [7:0] latch_we_i,
  input wire [7:0] pullup_sel_i,
  input wire [7:0] rt_buffer_i,
  input wire [1:0] rt_low_trig_sel_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  dir_follow_a: assert property (!$past(reset_i) |->
    {pin_oe_n_o[63:24],pin_oe_n_o[15:0]}=={$past(dir_in_i[63:24]),
    $past(dir_in_i[15:0])}) else $error("direction mismatch");
  inonly_oe_a: assert property (pin_oe_n_o[23:16]==8'hff)
    else $error("input port drives");
  pu_group_a: assert property (pullup_en_o[23:16]==
    {{6{pullup_sel_i[2]}},2'h0}) else $error("group pullup wrong");
  pu_inputs_a: assert property (pullup_en_o[7:0]==
    ({8{pullup_sel_i[0]}}&pin_oe_n_o[7:0])) else $error("pullup on output");
  pu_none_a: assert property (pullup_en_o[63:56]==8'h00)
    else $error("port seven pullup");
  rt_copy_a: assert property (timer1_match_i && rt_low_trig_sel_i==2'h1
    && !latch_we_i[0] |-> ##2 pin_o[3:0]==$past(rt_buffer_i[3:0],2))
    else $error("rt copy");
  out_latch_a: assert property (latch_we_i[1] |-> ##2
    pin_o[15:8]==$past(latch_wdata_i[15:8],2)) else $error("latch drive");
  cover property (timer1_match_i && rt_low_trig_sel_i==2'h1);
  cover property (latch_we_i[1]);
  cover property (pullup_sel_i[2]);
  cover property (timer1_match_i && latch_we_i[0]);
endmodule
bind multi_port_gpio gpio_checker gpio_checker_inst(
  .core_clk_i(core_clk_i),
  .reset_i(reset_i),
  .timer1_match_i(timer1_match_i),
  .latch_wdata_i(latch_wdata_i),
  .dir_in_i(dir_in_i),
  .pin_o(pin_o),
  .pin_oe_n_o(pin_oe_n_o),
  .pullup_en_o(pullup_en_o),
  .latch_we_i(latch_we_i),
  .pullup_sel_i(pullup_sel_i),
  .rt_buffer_i(rt_buffer_i),
  .rt_low_trig_sel_i(rt_low_trig_sel_i)
);

//--- tb/multi_port_gpio_tb_top.sv
// Self-checking bench for the eight-port I/O block.
`timescale 1ns/100ps
module multi_port_gpio_tb_top;
  logic clk = 0, rst = 1, t1 = 0, ex = 0;
  logic [63:0] wd = 0, dir = '1, pin, po, oe, pu, rd, de = 0, dv = 0;
  logic [7:0] we = 0, ps = 8'hff, rb = 8'h9c;
  logic [1:0] ls = 2'h1, hs = 2'h2;
  int fails = 0, n_checks = 0;
  initial forever #5 clk = ~clk;
  multi_port_gpio multi_port_gpio_inst(.core_clk_i(clk), .reset_i(rst),
    .latch_wdata_i(wd), .latch_we_i(we), .dir_in_i(dir), .pullup_sel_i(ps),
    .rt_buffer_i(rb), .rt_low_trig_sel_i(ls), .rt_high_trig_sel_i(hs),
    .timer1_match_i(t1), .ext_trig_i(ex), .pin_i(pin), .pin_o(po),
    .pin_oe_n_o(oe), .pullup_en_o(pu), .read_data_o(rd));
  ext_pins ext_pins_inst(.clk_i(clk), .pin_drv_i(po), .oe_n_i(oe),
    .pu_i(pu), .drv_i(dv), .drv_en_i(de), .pin_i(pin));
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task write_latch(input int p, input logic [7:0] d);
    wd[p*8 +: 8] = d;
    we[p] = 1'h1;
    cyc(1);
    we[p] = 1'h0;
    cyc(1);
  endtask
  task read_port(input int p, input logic [7:0] e);
    chk(rd[p*8 +: 8], e);
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %0t got %h exp %h", $time, g, e);
    end
  endtask
  task summarize;
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(4);
    rst = 0;
    chk(oe[15:8], 8'hff);
    dir[15:0] = 16'hf000;
    write_latch(1, 8'ha5);
    cyc(5);
    chk(oe[15:8], 8'hf0);
    chk(pu[15:8], 8'hf0);
    chk(pu[7:0], 8'h00);
    read_port(1, 8'hf5);
    dir[23:16] = 8'h00;
    de[23:16] = 8'hff;
    dv[23:16] = 8'h3c;
    cyc(7);
    chk(oe[23:16], 8'hff);
    chk(pu[23:16], 8'hfc);
    chk(pu[31:24], 8'hff);
    chk(pu[63:56], 8'h00);
    read_port(2, 8'h3c);
    t1 = 1;
    cyc(1);
    t1 = 0;
    cyc(2);
    chk(po[7:0], 8'h0c);
    ex = 1;
    cyc(8);
    chk(po[7:0], 8'h9c);
    ls = 2'h0;
    hs = 2'h1;
    rb = 8'h3a;
    t1 = 1;
    cyc(1);
    t1 = 0;
    cyc(2);
    chk(po[7:0], 8'h3c);
    t1 = 1;
    wd[7:0] = 8'h66;
    we = 8'h01;
    cyc(1);
    t1 = 0;
    we = 8'h00;
    cyc(2);
    chk(po[7:0], 8'h66);
    read_port(0, 8'h66);
    summarize();
  end
endmodule
